// ===== irq_flag_pkg.sv
`default_nettype none
package irq_flag_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] REQ_LOW_IDX   = 16'hFFE0;
  localparam logic [15:0] REQ_HIGH_IDX  = 16'hFFE1;
  localparam logic [15:0] MASK_LOW_IDX  = 16'hFFE4;
  localparam logic [15:0] MASK_HIGH_IDX = 16'hFFE5;
  localparam logic [15:0] EDGE_SEL_IDX  = 16'hFFEC;
  localparam logic [15:0] KEY_SEL_IDX   = 16'hFFF5;
  localparam logic [15:0] CTRL_IDX      = 16'hFFF8;
  localparam logic [15:0] STATUS_IDX    = 16'hFFF9;

  localparam logic [7:0] REQ_RESET     = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'hFF;
  localparam logic [7:0] SEL_RESET     = 8'h00;
  localparam logic [7:0] REQ_HIGH_KEEP = 8'h81;
  localparam logic [7:0] REQ_LOW_KEEP  = 8'h7F;

  // Field positions: low registers
  localparam int WDT_BIT   = 0;
  localparam int PIN0_BIT  = 1;
  localparam int PIN1_BIT  = 2;
  localparam int PIN2_BIT  = 3;
  localparam int SRX_BIT   = 4;
  localparam int STX_BIT   = 5;
  localparam int BTM_BIT   = 6;
  // High registers
  localparam int KEY_BIT   = 0;
  localparam int WTM_BIT   = 7;
  // Control register
  localparam int CTRL_IE_BIT = 0;
  localparam int CTRL_WM_LSB = 1;

  localparam int NUM_SRC   = 9;

  localparam logic [15:0] VEC_WDT  = 16'h0004;
  localparam logic [15:0] VEC_PIN0 = 16'h0006;
  localparam logic [15:0] VEC_PIN1 = 16'h0008;
  localparam logic [15:0] VEC_PIN2 = 16'h000A;
  localparam logic [15:0] VEC_SER  = 16'h000C;
  localparam logic [15:0] VEC_STX  = 16'h000E;
  localparam logic [15:0] VEC_BTM  = 16'h0010;
  localparam logic [15:0] VEC_WTM  = 16'h0014;
  localparam logic [15:0] VEC_KEY  = 16'h002A;

  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [1:0] {WD_INTERVAL, WD_MODE1, WD_MODE2} wd_mode_t;

  typedef struct packed {
    logic wdt_overflow;
    logic async_rx_done_request;
    logic three_wire_done_request;
    logic async_tx_done_request;
    logic byte_timer_match_request;
    logic wide_timer_match_request;
  } periph_evt_t;

  typedef struct packed {
    logic        nmi_req;
    logic        irq_req;
    logic [3:0]  irq_level;
    logic [15:0] vector;
  } core_req_t;

  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_d;
    logic [4:0] key_s1;
    logic [4:0] key_s2;
    logic [4:0] key_d;
    logic [7:0] req_low;
    logic [7:0] req_high;
    logic [7:0] mask_low;
    logic [7:0] mask_high;
    logic [7:0] edge_sel;
    logic [7:0] key_sel;
    logic       global_irq_enable;
    wd_mode_t   wd_mode;
    logic       nmi_pend;
    logic [31:0] prdata;
  } ctl_state_t;

endpackage
`default_nettype wire

// ===== prioritized_interrupt_flag_controller.sv
// How it works
// - Ten sources: one non-maskable, nine maskable.
// - Watchdog overflow in watchdog mode 1 raises non-maskable request, vector 0004H.
// - Watchdog overflow in interval mode raises maskable request, level 0.
// - Pin edges 0,1,2 raise levels 1,2,3, vectors 0006H, 0008H, 000AH.
// - Serial receive and three-wire done share level 4, vector 000CH, one flag.
// - Serial transmit done raises level 5, vector 000EH.
// - Byte timer match raises level 6, vector 0010H.
// - Wide timer match raises level 7, vector 0014H.
// - Key return raises lowest level 8, vector 002AH.
// - Among pending maskable requests the smallest level wins.
// - Request flags set by source or write, cleared by acknowledge, reset, write.
// - Request flag registers reset to 00H; bit and byte writes.
// - Watchdog request flag usable only in interval mode.
// - Mask zero enables servicing, mask one disables.
// - Mask registers reset to FFH; bit and byte writes.
// - Watchdog mask read in watchdog modes is undefined.
// - Pin level change in output mode sets its request flag.
// - Maskable request offered only when flag 1, mask 0, global enable 1.
// - Non-maskable request ignores global enable and beats all maskable ones.
// - Pin edge select: 00 fall, 01 rise, 11 both, 10 prohibited.
// - Key request on falling edge of any selected key pin.
`timescale 1ns/1ns
`default_nettype none
module prioritized_interrupt_flag_controller (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [17:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [2:0]                ext_pin,
  input  wire logic [4:0]                key_pin,
  input  wire irq_flag_pkg::periph_evt_t periph_evt,
  output irq_flag_pkg::core_req_t        core_req,
  input  wire logic                      ack,
  input  wire logic                      nmi_ack,
  input  wire logic                      global_irq_clear
);

  irq_flag_pkg::ctl_state_t s_reg;
  irq_flag_pkg::ctl_state_t s_next;

  logic [15:0] idx;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [8:0]  pend;
  logic [8:0]  flags;
  logic [8:0]  masks;
  logic [3:0]  win;
  logic        any;
  logic [2:0]  pin_edge;
  logic        key_fall;

  // Flags and masks in priority order 0..8
  function automatic logic [8:0] order(input logic [7:0] lo, input logic [7:0] hi);
    order = {hi[irq_flag_pkg::KEY_BIT], hi[irq_flag_pkg::WTM_BIT], lo[6:0]};
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] lvl);
    case (lvl)
      4'h0:    vec_of = irq_flag_pkg::VEC_WDT;
      4'h1:    vec_of = irq_flag_pkg::VEC_PIN0;
      4'h2:    vec_of = irq_flag_pkg::VEC_PIN1;
      4'h3:    vec_of = irq_flag_pkg::VEC_PIN2;
      4'h4:    vec_of = irq_flag_pkg::VEC_SER;
      4'h5:    vec_of = irq_flag_pkg::VEC_STX;
      4'h6:    vec_of = irq_flag_pkg::VEC_BTM;
      4'h7:    vec_of = irq_flag_pkg::VEC_WTM;
      default: vec_of = irq_flag_pkg::VEC_KEY;
    endcase
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic old_v, input logic new_v);
    case (sel)
      irq_flag_pkg::EDGE_FALL: edge_hit = old_v & ~new_v;
      irq_flag_pkg::EDGE_RISE: edge_hit = ~old_v & new_v;
      irq_flag_pkg::EDGE_BOTH: edge_hit = old_v ^ new_v;
      default:                 edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] wv, input logic en);
    merge = en ? wv : old_v;
  endfunction

  assign idx     = paddr[17:2];
  assign acc     = psel & penable;
  assign hit     = (idx == irq_flag_pkg::REQ_LOW_IDX) | (idx == irq_flag_pkg::REQ_HIGH_IDX) |
                   (idx == irq_flag_pkg::MASK_LOW_IDX) | (idx == irq_flag_pkg::MASK_HIGH_IDX) |
                   (idx == irq_flag_pkg::EDGE_SEL_IDX) | (idx == irq_flag_pkg::KEY_SEL_IDX) |
                   (idx == irq_flag_pkg::CTRL_IDX) | (idx == irq_flag_pkg::STATUS_IDX);
  assign wr      = acc & pwrite & hit & pstrb[0];
  assign rd      = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = s_reg.prdata;

  assign flags = order(s_reg.req_low, s_reg.req_high);
  assign masks = order(s_reg.mask_low, s_reg.mask_high);
  assign pend  = flags & ~masks & {9{s_reg.global_irq_enable}};

  always_comb begin
    win = 4'h0;
    any = 1'b0;
    for (int i = irq_flag_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win = 4'(i);
        any = 1'b1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_edge[i] = edge_hit(s_reg.edge_sel[2 * i + 2 +: 2], s_reg.pin_d[i], s_reg.pin_s2[i]);
    end
  end
  // Key select bit 0 covers key pin 0 only; bits 4..7 cover pins 1..4, one pin each
  assign key_fall = |(s_reg.key_d & ~s_reg.key_s2 &
                      {s_reg.key_sel[7:4], s_reg.key_sel[0]});

  always_comb begin
    s_next        = s_reg;
    s_next.pin_s1 = ext_pin;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_d  = s_reg.pin_s2;
    s_next.key_s1 = key_pin;
    s_next.key_s2 = s_reg.key_s1;
    s_next.key_d  = s_reg.key_s2;

    // Software writes first; hardware sets below win over a same-cycle clear
    if (wr) begin
      case (idx)
        irq_flag_pkg::REQ_LOW_IDX:   s_next.req_low  = merge(s_reg.req_low, pwdata[7:0], 1'b1);
        irq_flag_pkg::REQ_HIGH_IDX:  s_next.req_high = merge(s_reg.req_high, pwdata[7:0], 1'b1);
        irq_flag_pkg::MASK_LOW_IDX:  s_next.mask_low = merge(s_reg.mask_low, pwdata[7:0], 1'b1);
        irq_flag_pkg::MASK_HIGH_IDX: s_next.mask_high = merge(s_reg.mask_high, pwdata[7:0], 1'b1);
        irq_flag_pkg::EDGE_SEL_IDX:  s_next.edge_sel = pwdata[7:0];
        irq_flag_pkg::KEY_SEL_IDX:   s_next.key_sel  = pwdata[7:0];
        irq_flag_pkg::CTRL_IDX: begin
          s_next.global_irq_enable = pwdata[irq_flag_pkg::CTRL_IE_BIT];
          case (pwdata[irq_flag_pkg::CTRL_WM_LSB +: 2])
            2'h1:    s_next.wd_mode = irq_flag_pkg::WD_MODE1;
            2'h2:    s_next.wd_mode = irq_flag_pkg::WD_MODE2;
            default: s_next.wd_mode = irq_flag_pkg::WD_INTERVAL;
          endcase
        end
        default: ;
      endcase
    end

    // Acknowledge clears the winning flag; acceptance also drops global enable
    if (ack & any) begin
      s_next.global_irq_enable = 1'b0;
      case (win)
        4'h7:    s_next.req_high[irq_flag_pkg::WTM_BIT] = 1'b0;
        4'h8:    s_next.req_high[irq_flag_pkg::KEY_BIT] = 1'b0;
        default: s_next.req_low[win[2:0]] = 1'b0;
      endcase
    end
    if (global_irq_clear) begin
      s_next.global_irq_enable = 1'b0;
    end
    if (nmi_ack) begin
      s_next.nmi_pend          = 1'b0;
      s_next.global_irq_enable = 1'b0;
    end

    if (periph_evt.wdt_overflow) begin
      if (s_reg.wd_mode == irq_flag_pkg::WD_INTERVAL) begin
        s_next.req_low[irq_flag_pkg::WDT_BIT] = 1'b1;
      end else if (s_reg.wd_mode == irq_flag_pkg::WD_MODE1) begin
        s_next.nmi_pend = 1'b1;
      end
    end
    // Outside interval mode the flag is held clear
    if (s_reg.wd_mode != irq_flag_pkg::WD_INTERVAL) begin
      s_next.req_low[irq_flag_pkg::WDT_BIT] = 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      if (pin_edge[i]) begin
        s_next.req_low[irq_flag_pkg::PIN0_BIT + i] = 1'b1;
      end
    end
    if (periph_evt.async_rx_done_request | periph_evt.three_wire_done_request) begin
      s_next.req_low[irq_flag_pkg::SRX_BIT] = 1'b1;
    end
    if (periph_evt.async_tx_done_request) begin
      s_next.req_low[irq_flag_pkg::STX_BIT] = 1'b1;
    end
    if (periph_evt.byte_timer_match_request) begin
      s_next.req_low[irq_flag_pkg::BTM_BIT] = 1'b1;
    end
    if (periph_evt.wide_timer_match_request) begin
      s_next.req_high[irq_flag_pkg::WTM_BIT] = 1'b1;
    end
    if (key_fall) begin
      s_next.req_high[irq_flag_pkg::KEY_BIT] = 1'b1;
    end
    // Unused request bits stay clear even if software misbehaves
    s_next.req_low  = s_next.req_low & irq_flag_pkg::REQ_LOW_KEEP;
    s_next.req_high = s_next.req_high & irq_flag_pkg::REQ_HIGH_KEEP;

    if (rd) begin
      case (idx)
        irq_flag_pkg::REQ_LOW_IDX:   s_next.prdata = {24'h000000, s_reg.req_low};
        irq_flag_pkg::REQ_HIGH_IDX:  s_next.prdata = {24'h000000, s_reg.req_high};
        irq_flag_pkg::MASK_LOW_IDX:  s_next.prdata = {24'h000000, s_reg.mask_low};
        irq_flag_pkg::MASK_HIGH_IDX: s_next.prdata = {24'h000000, s_reg.mask_high};
        irq_flag_pkg::EDGE_SEL_IDX:  s_next.prdata = {24'h000000, s_reg.edge_sel};
        irq_flag_pkg::KEY_SEL_IDX:   s_next.prdata = {24'h000000, s_reg.key_sel};
        irq_flag_pkg::CTRL_IDX:
          s_next.prdata = {29'h0, s_reg.wd_mode, s_reg.global_irq_enable};
        irq_flag_pkg::STATUS_IDX:
          s_next.prdata = {26'h0, s_reg.nmi_pend, any, win};
        default: s_next.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg           <= '0;
      s_reg.req_low   <= irq_flag_pkg::REQ_RESET;
      s_reg.req_high  <= irq_flag_pkg::REQ_RESET;
      s_reg.mask_low  <= irq_flag_pkg::MASK_RESET;
      s_reg.mask_high <= irq_flag_pkg::MASK_RESET;
      s_reg.edge_sel  <= irq_flag_pkg::SEL_RESET;
      s_reg.key_sel   <= irq_flag_pkg::SEL_RESET;
      s_reg.wd_mode   <= irq_flag_pkg::WD_INTERVAL;
    end else begin
      s_reg <= s_next;
    end
  end

  // Non-maskable path bypasses global enable and priority
  always_comb begin
    core_req.nmi_req   = s_reg.nmi_pend;
    core_req.irq_req   = any & ~s_reg.nmi_pend;
    core_req.irq_level = win;
    core_req.vector    = s_reg.nmi_pend ? irq_flag_pkg::VEC_WDT : vec_of(win);
  end

  property p_nmi_first;
    @(posedge pclk) disable iff (!presetn) s_reg.nmi_pend |-> !core_req.irq_req && core_req.vector == 16'h0004;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("nmi not first");

  property p_gate;
    @(posedge pclk) disable iff (!presetn) core_req.irq_req |-> s_reg.global_irq_enable && flags[win] && !masks[win];
  endproperty
  a_gate: assert property (p_gate) else $error("ungated request offered");

  property p_prio;
    @(posedge pclk) disable iff (!presetn) any |-> (pend & ((9'h001 << win) - 9'h001)) == 9'h000;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");

  property p_btm_set;
    @(posedge pclk) disable iff (!presetn) periph_evt.byte_timer_match_request |=> s_reg.req_low[6];
  endproperty
  a_btm_set: assert property (p_btm_set) else $error("byte timer flag lost");

  property p_wtm_set;
    @(posedge pclk) disable iff (!presetn) periph_evt.wide_timer_match_request |=> s_reg.req_high[7];
  endproperty
  a_wtm_set: assert property (p_wtm_set) else $error("wide timer flag lost");

  property p_ser_set;
    @(posedge pclk) disable iff (!presetn)
      (periph_evt.async_rx_done_request || periph_evt.three_wire_done_request) |=> s_reg.req_low[4];
  endproperty
  a_ser_set: assert property (p_ser_set) else $error("serial flag lost");

  property p_wdt_nmi;
    @(posedge pclk) disable iff (!presetn)
      periph_evt.wdt_overflow && s_reg.wd_mode == irq_flag_pkg::WD_MODE1 |=> core_req.nmi_req;
  endproperty
  a_wdt_nmi: assert property (p_wdt_nmi) else $error("watchdog nmi missing");

  property p_wdt_hold;
    @(posedge pclk) disable iff (!presetn) s_reg.wd_mode != irq_flag_pkg::WD_INTERVAL |-> ##1 !s_reg.req_low[0];
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog flag not held");

  property p_vec;
    @(posedge pclk) disable iff (!presetn) core_req.irq_req && win == 4'h8 |-> core_req.vector == 16'h002A;
  endproperty
  a_vec: assert property (p_vec) else $error("key vector wrong");

  property p_unused;
    @(posedge pclk) disable iff (!presetn) !s_reg.req_low[7] && s_reg.req_high[6:1] == 6'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused flag set");

  property p_ie_gate;
    @(posedge pclk) disable iff (!presetn) !s_reg.global_irq_enable |-> !core_req.irq_req;
  endproperty
  a_ie_gate: assert property (p_ie_gate) else $error("request offered while disabled");

  property p_ack_ie;
    @(posedge pclk) disable iff (!presetn) ack && any |=> !s_reg.global_irq_enable;
  endproperty
  a_ack_ie: assert property (p_ack_ie) else $error("enable kept after acceptance");

  property p_nmi_clear;
    @(posedge pclk) disable iff (!presetn) nmi_ack && !periph_evt.wdt_overflow |=> !core_req.nmi_req;
  endproperty
  a_nmi_clear: assert property (p_nmi_clear) else $error("nmi kept after acceptance");

  property p_wdt_flag;
    @(posedge pclk) disable iff (!presetn)
      periph_evt.wdt_overflow && s_reg.wd_mode == irq_flag_pkg::WD_INTERVAL |=> s_reg.req_low[0];
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("interval flag lost");

  // Mode 2 overflow must not reach the core as a request
  property p_wdt_quiet;
    @(posedge pclk) disable iff (!presetn)
      periph_evt.wdt_overflow && s_reg.wd_mode == irq_flag_pkg::WD_MODE2 && !s_reg.nmi_pend
      |=> !core_req.nmi_req;
  endproperty
  a_wdt_quiet: assert property (p_wdt_quiet) else $error("mode 2 raised nmi");

  property p_pin_set;
    @(posedge pclk) disable iff (!presetn)
      pin_edge != 3'h0 |=> (s_reg.req_low[3:1] & $past(pin_edge)) == $past(pin_edge);
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("pin flag lost");

  property p_key_set;
    @(posedge pclk) disable iff (!presetn) key_fall |=> s_reg.req_high[0];
  endproperty
  a_key_set: assert property (p_key_set) else $error("key flag lost");

  property p_stx_set;
    @(posedge pclk) disable iff (!presetn) periph_evt.async_tx_done_request |=> s_reg.req_low[5];
  endproperty
  a_stx_set: assert property (p_stx_set) else $error("transmit flag lost");

  c_nmi: cover property (@(posedge pclk) disable iff (!presetn) core_req.nmi_req);
  c_key: cover property (@(posedge pclk) disable iff (!presetn) core_req.irq_req && win == 4'h8);
  c_ack: cover property (@(posedge pclk) disable iff (!presetn) ack && any ##1 !any);
  c_pin: cover property (@(posedge pclk) disable iff (!presetn) pin_edge != 3'h0);
  c_nmi_over: cover property (@(posedge pclk) disable iff (!presetn) core_req.nmi_req && any);

endmodule
`default_nettype wire

// ===== core_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stands in for the core's acceptance logic: one acknowledge per offered request
module core_model (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire irq_flag_pkg::core_req_t core_req,
  input  wire logic                    take_on,
  output logic                         ack,
  output logic                         nmi_ack,
  output logic [15:0]                  seen_vec,
  output logic [3:0]                   seen_lvl,
  output logic [7:0]                   n_taken
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack      <= 1'b0;
      nmi_ack  <= 1'b0;
      seen_vec <= 16'h0000;
      seen_lvl <= 4'h0;
      n_taken  <= 8'h00;
    end else begin
      ack     <= 1'b0;
      nmi_ack <= 1'b0;
      // Skip the cycle after a pulse: the request has not dropped yet
      if (take_on && !ack && !nmi_ack) begin
        if (core_req.nmi_req) begin
          nmi_ack  <= 1'b1;
          seen_vec <= core_req.vector;
          n_taken  <= n_taken + 8'h01;
        end else if (core_req.irq_req) begin
          ack      <= 1'b1;
          seen_vec <= core_req.vector;
          seen_lvl <= core_req.irq_level;
          n_taken  <= n_taken + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== prioritized_interrupt_flag_controller_test.sv
`timescale 1ns/1ns
`default_nettype none
module prioritized_interrupt_flag_controller_test;
  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [17:0]               paddr = 18'h00000;
  logic [31:0]               pwdata = 32'h00000000;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic [2:0]                ext_pin = 3'h0;
  logic [4:0]                key_pin = 5'h1F;
  irq_flag_pkg::periph_evt_t periph_evt = '0;
  irq_flag_pkg::core_req_t   core_req;
  logic                      ack;
  logic                      nmi_ack;
  logic                      take_on = 1'b0;
  logic                      irq_off = 1'b0;
  logic [15:0]               seen_vec;
  logic [3:0]                seen_lvl;
  logic [7:0]                n_taken;
  logic [31:0]               rd;
  logic                      err;
  int                        n_mismatch = 0;
  int                        cmp_count = 0;
  int                        cycles = 0;

  always #50 pclk = ~pclk;

  prioritized_interrupt_flag_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_pin(ext_pin), .key_pin(key_pin), .periph_evt(periph_evt), .core_req(core_req),
    .ack(ack), .nmi_ack(nmi_ack), .global_irq_clear(irq_off));

  core_model partner (.pclk(pclk), .presetn(presetn), .core_req(core_req), .take_on(take_on), .ack(ack),
    .nmi_ack(nmi_ack), .seen_vec(seen_vec), .seen_lvl(seen_lvl), .n_taken(n_taken));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      n_mismatch = n_mismatch + 1;
    end
  endtask

  // Byte address is four times the register index
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] data);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, data};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_check(input string name, input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, rd, {24'h000000, exp});
  endtask

  task automatic pulse(input irq_flag_pkg::periph_evt_t e);
    @(posedge pclk);
    periph_evt <= e;
    @(posedge pclk);
    periph_evt <= '0;
  endtask

  task automatic wait_taken(input logic [7:0] n);
    while (n_taken !== n) @(posedge pclk);
  endtask

  task automatic t_reset();
    rd_check("req_low", irq_flag_pkg::REQ_LOW_IDX, 8'h00);
    rd_check("req_high", irq_flag_pkg::REQ_HIGH_IDX, 8'h00);
    rd_check("mask_low", irq_flag_pkg::MASK_LOW_IDX, 8'hFF);
    rd_check("mask_high", irq_flag_pkg::MASK_HIGH_IDX, 8'hFF);
    apb(1'b0, 16'hFFE2, 8'h00);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_events();
    logic [15:0] exp [6] = '{16'h8000, 16'h0040, 16'h0020, 16'h0010, 16'h0010, 16'h0001};
    for (int k = 0; k < 6; k++) begin
      pulse(irq_flag_pkg::periph_evt_t'(6'h01 << k));
      rd_check("evt low", irq_flag_pkg::REQ_LOW_IDX, exp[k][7:0]);
      rd_check("evt high", irq_flag_pkg::REQ_HIGH_IDX, exp[k][15:8]);
      apb(1'b1, irq_flag_pkg::REQ_LOW_IDX, 8'h00);
      apb(1'b1, irq_flag_pkg::REQ_HIGH_IDX, 8'h00);
      rd_check("evt cleared", irq_flag_pkg::REQ_LOW_IDX, 8'h00);
    end
    $display("test events done");
  endtask

  task automatic t_priority();
    logic [15:0] vt [9] = '{irq_flag_pkg::VEC_WDT, irq_flag_pkg::VEC_PIN0, irq_flag_pkg::VEC_PIN1,
      irq_flag_pkg::VEC_PIN2, irq_flag_pkg::VEC_SER, irq_flag_pkg::VEC_STX, irq_flag_pkg::VEC_BTM,
      irq_flag_pkg::VEC_WTM, irq_flag_pkg::VEC_KEY};
    logic [7:0] base;
    base = n_taken;
    apb(1'b1, irq_flag_pkg::REQ_LOW_IDX, 8'h7F);
    apb(1'b1, irq_flag_pkg::REQ_HIGH_IDX, 8'h81);
    apb(1'b1, irq_flag_pkg::CTRL_IDX, 8'h01);
    @(negedge pclk);
    check("masked irq", {31'h0, core_req.irq_req}, 32'h0);
    apb(1'b1, irq_flag_pkg::MASK_LOW_IDX, 8'h80);
    apb(1'b1, irq_flag_pkg::MASK_HIGH_IDX, 8'h7E);
    take_on <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wait_taken(base + 8'(i + 1));
      check("level", {28'h0, seen_lvl}, i);
      check("vector", {16'h0, seen_vec}, {16'h0, vt[i]});
      repeat (2) @(posedge pclk);
      check("ie off", {31'h0, core_req.irq_req}, 32'h0);
      apb(1'b1, irq_flag_pkg::CTRL_IDX, 8'h01);
    end
    take_on <= 1'b0;
    rd_check("acked low", irq_flag_pkg::REQ_LOW_IDX, 8'h00);
    rd_check("acked high", irq_flag_pkg::REQ_HIGH_IDX, 8'h00);
    apb(1'b1, irq_flag_pkg::MASK_LOW_IDX, 8'hFF);
    apb(1'b1, irq_flag_pkg::MASK_HIGH_IDX, 8'hFF);
    $display("test priority done");
  endtask

  task automatic t_nmi();
    logic [7:0] base;
    base = n_taken;
    apb(1'b1, irq_flag_pkg::REQ_LOW_IDX, 8'h02);
    apb(1'b1, irq_flag_pkg::MASK_LOW_IDX, 8'hFD);
    apb(1'b1, irq_flag_pkg::CTRL_IDX, 8'h03);
    pulse(irq_flag_pkg::periph_evt_t'(6'h20));
    @(posedge pclk);
    check("nmi req", {31'h0, core_req.nmi_req}, 32'h1);
    check("nmi over irq", {31'h0, core_req.irq_req}, 32'h0);
    rd_check("wdt flag", irq_flag_pkg::REQ_LOW_IDX, 8'h02);
    take_on <= 1'b1;
    wait_taken(base + 8'h01);
    take_on <= 1'b0;
    check("nmi vector", {16'h0, seen_vec}, {16'h0, irq_flag_pkg::VEC_WDT});
    @(posedge pclk);
    check("nmi dropped", {31'h0, core_req.nmi_req}, 32'h0);
    check("ie after nmi", {31'h0, core_req.irq_req}, 32'h0);
    apb(1'b1, irq_flag_pkg::CTRL_IDX, 8'h03);
    rd_check("status", irq_flag_pkg::STATUS_IDX, 8'h11);
    @(posedge pclk);
    irq_off <= 1'b1;
    @(posedge pclk);
    irq_off <= 1'b0;
    @(negedge pclk);
    check("ie cleared", {31'h0, core_req.irq_req}, 32'h0);
    apb(1'b1, irq_flag_pkg::REQ_LOW_IDX, 8'h00);
    apb(1'b1, irq_flag_pkg::MASK_LOW_IDX, 8'hFF);
    apb(1'b1, irq_flag_pkg::CTRL_IDX, 8'h04);
    pulse(irq_flag_pkg::periph_evt_t'(6'h20));
    @(negedge pclk);
    check("mode2 no nmi", {31'h0, core_req.nmi_req}, 32'h0);
    rd_check("mode2 wdt flag", irq_flag_pkg::REQ_LOW_IDX, 8'h00);
    apb(1'b1, irq_flag_pkg::CTRL_IDX, 8'h00);
    $display("test nmi done");
  endtask

  task automatic t_pins();
    logic [1:0] codes [3] = '{irq_flag_pkg::EDGE_FALL, irq_flag_pkg::EDGE_RISE, irq_flag_pkg::EDGE_BOTH};
    logic [7:0] bitv;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 3; c++) begin
        bitv = 8'h02 << p;
        apb(1'b1, irq_flag_pkg::EDGE_SEL_IDX, 8'({codes[c], 2'b00}) << (2 * p));
        apb(1'b1, irq_flag_pkg::REQ_LOW_IDX, 8'h00);
        ext_pin[p] <= 1'b1;
        repeat (6) @(posedge pclk);
        rd_check("rise", irq_flag_pkg::REQ_LOW_IDX, codes[c][0] ? bitv : 8'h00);
        apb(1'b1, irq_flag_pkg::REQ_LOW_IDX, 8'h00);
        ext_pin[p] <= 1'b0;
        repeat (6) @(posedge pclk);
        rd_check("fall", irq_flag_pkg::REQ_LOW_IDX, codes[c] != 2'h1 ? bitv : 8'h00);
      end
    end
    apb(1'b1, irq_flag_pkg::EDGE_SEL_IDX, 8'h00);
    apb(1'b1, irq_flag_pkg::REQ_LOW_IDX, 8'h00);
    apb(1'b1, irq_flag_pkg::KEY_SEL_IDX, 8'h01);
    key_pin[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    rd_check("key fall", irq_flag_pkg::REQ_HIGH_IDX, 8'h01);
    apb(1'b1, irq_flag_pkg::REQ_HIGH_IDX, 8'h00);
    key_pin[0] <= 1'b1;
    repeat (6) @(posedge pclk);
    rd_check("key rise", irq_flag_pkg::REQ_HIGH_IDX, 8'h00);
    $display("test pins done");
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_priority();
    t_nmi();
    t_pins();
    end_sim();
  end
endmodule
`default_nettype wire
